/* ide_pio_cycle_timing_regs.sv */
// register bank holding ide command strobe timing counts
// assumes an axi4-lite master on aclk; outputs feed the strobe sequencers
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - sector count bits 12-8 in upper register
// - channel 1 command port recovery count
// - codes 1..31 direct, zero means 32 clocks
// - channel 1 disk 0 read recovery count
// - channel 1 disk 0 write recovery count
// - channel 1 disk 1 read recovery count
// - channel 1 disk 1 write recovery count
// - channel 2 command port active count
// - channel 2 command port recovery count
// - channel 2 disk 0 read active count
// - channel 2 disk 0 write active count
// - channel 2 disk 1 read active count
// - channel 2 disk 1 write active count
// - channel 2 disk 0 read recovery count
// - bits 7-5 reserved, reset zero
// - sector count low two bits read zero
// - channel 2 disk 1 buffer use gated globally
module ide_pio_cycle_timing_regs
   import ide_timing_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // read address
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // timing in cpu clocks, entry k is the register at first index plus k
   output timing_clocks_t timing_clocks,
   // sector size and buffer steering
   output buffer_cfg_t buffer_cfg
);

   logic [NUM_TIMING-1:0][COUNT_W-1:0] timing_count;
   logic [7:SECTOR_LOW_LSB] sector_low;
   logic [COUNT_W-1:0] sector_high;
   logic buf_global;
   logic buf_ch2_disk1;
   logic aw_held;
   logic w_held;
   logic [5:0] aw_index;
   logic [7:0] w_byte;
   logic w_lane0;
   logic do_write;
   logic [5:0] ar_index;
   logic [7:0] next_rbyte;
   logic next_rmapped;

   assign do_write = aw_held && w_held && !bvalid;
   assign ar_index = araddr[7:2];

   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx == IDX_BUF_GLOBAL) || (idx == IDX_BUF_DISK) ||
         (idx == IDX_SECTOR_LOW) || (idx == IDX_SECTOR_HIGH) ||
         ((idx >= IDX_TIMING_FIRST) && (idx <= IDX_TIMING_LAST));
   endfunction

   // write address channel; taken in either order against write data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         aw_held <= 1'b0;
         aw_index <= 6'h00;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            aw_index <= awaddr[7:2];
         end
         if (do_write) begin
            aw_held <= 1'b0;
         end
         // ready comes back only once the response is gone
         if (bvalid && bready) begin
            awready <= 1'b1;
         end
      end
   end

   // write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b1;
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else begin
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_held <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane0 <= wstrb[0];
         end
         if (do_write) begin
            w_held <= 1'b0;
         end
         if (bvalid && bready) begin
            wready <= 1'b1;
         end
      end
   end

   // one response per stored pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= mapped(aw_index) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // only byte lane 0 carries register data; upper lanes are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sector_low <= SECTOR_RESET[7:SECTOR_LOW_LSB];
         sector_high <= SECTOR_RESET[COUNT_MSB:COUNT_LSB];
         buf_global <= BUF_RESET[BUF_GLOBAL_BIT];
         buf_ch2_disk1 <= BUF_RESET[BUF_CH2_DISK1_BIT];
      end else if (do_write && w_lane0) begin
         if (aw_index == IDX_SECTOR_LOW)
            sector_low <= w_byte[7:SECTOR_LOW_LSB];
         if (aw_index == IDX_SECTOR_HIGH)
            sector_high <= w_byte[COUNT_MSB:COUNT_LSB];
         if (aw_index == IDX_BUF_GLOBAL)
            buf_global <= w_byte[BUF_GLOBAL_BIT];
         if (aw_index == IDX_BUF_DISK)
            buf_ch2_disk1 <= w_byte[BUF_CH2_DISK1_BIT];
      end
   end

   // one slot per timing register, contiguous indexes
   for (genvar k = 0; k < NUM_TIMING; k++) begin : g_timing
      localparam logic [5:0] IDX = 6'(IDX_TIMING_FIRST + k);
      // slot-local flops keep each packed entry to a single process
      logic [COUNT_W-1:0] count;
      logic [CLOCKS_W-1:0] clocks;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            count <= TIMING_RESET[COUNT_MSB:COUNT_LSB];
         end else if (do_write && w_lane0 && aw_index == IDX) begin
            count <= w_byte[COUNT_MSB:COUNT_LSB];
         end
      end
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            clocks <= MAX_CLOCKS;
         end else begin
            // zero code stretches to the longest time
            clocks <= (count == '0) ? MAX_CLOCKS : {1'b0, count};
         end
      end
      assign timing_count[k] = count;
      assign timing_clocks[k] = clocks;
   end

   // registered so the sequencers see a stable copy
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buffer_cfg <= '0;
      end else begin
         buffer_cfg.sector_bytes <= {sector_high, sector_low, 2'b00};
         buffer_cfg.ch2_disk1_buffer_use <= buf_global && buf_ch2_disk1;
      end
   end

   // read mux; reserved bits return zero
   always_comb begin
      next_rbyte = 8'h00;
      next_rmapped = mapped(ar_index);
      if (ar_index == IDX_SECTOR_LOW)
         next_rbyte = {sector_low, 2'b00};
      else if (ar_index == IDX_SECTOR_HIGH)
         next_rbyte = {3'b000, sector_high};
      else if (ar_index == IDX_BUF_GLOBAL)
         next_rbyte[BUF_GLOBAL_BIT] = buf_global;
      else if (ar_index == IDX_BUF_DISK)
         next_rbyte[BUF_CH2_DISK1_BIT] = buf_ch2_disk1;
      else if (next_rmapped)
         next_rbyte = {3'b000, timing_count[4'(ar_index - IDX_TIMING_FIRST)]};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, next_rbyte};
            rresp <= next_rmapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

/* ide_timing_pkg.sv */
// package for the ide command strobe timing register bank
// assumes axi4-lite access with 32-bit data, one register per word
package ide_timing_pkg;

   localparam int ADDR_W = 8;
   localparam int NUM_TIMING = 13;
   localparam int COUNT_W = 5;
   localparam int CLOCKS_W = 6;

   // register indexes; byte address is four times the index
   localparam logic [5:0] IDX_BUF_GLOBAL = 6'h07;
   localparam logic [5:0] IDX_BUF_DISK = 6'h0A;
   localparam logic [5:0] IDX_SECTOR_LOW = 6'h11;
   localparam logic [5:0] IDX_SECTOR_HIGH = 6'h12;
   localparam logic [5:0] IDX_CH1_CMD_PORT_RECOVERY = 6'h25;
   localparam logic [5:0] IDX_CH1_DISK0_READ_RECOVERY = 6'h26;
   localparam logic [5:0] IDX_CH1_DISK0_WRITE_RECOVERY = 6'h27;
   localparam logic [5:0] IDX_CH1_DISK1_READ_RECOVERY = 6'h28;
   localparam logic [5:0] IDX_CH1_DISK1_WRITE_RECOVERY = 6'h29;
   localparam logic [5:0] IDX_CH2_CMD_PORT_ACTIVE = 6'h2A;
   localparam logic [5:0] IDX_CH2_DISK0_READ_ACTIVE = 6'h2B;
   localparam logic [5:0] IDX_CH2_DISK0_WRITE_ACTIVE = 6'h2C;
   localparam logic [5:0] IDX_CH2_DISK1_READ_ACTIVE = 6'h2D;
   localparam logic [5:0] IDX_CH2_DISK1_WRITE_ACTIVE = 6'h2E;
   localparam logic [5:0] IDX_CH2_CMD_PORT_RECOVERY = 6'h2F;
   localparam logic [5:0] IDX_CH2_DISK0_READ_RECOVERY = 6'h30;
   localparam logic [5:0] IDX_CH2_DISK0_WRITE_RECOVERY = 6'h31;
   localparam logic [5:0] IDX_TIMING_FIRST = IDX_CH1_CMD_PORT_RECOVERY;
   localparam logic [5:0] IDX_TIMING_LAST = IDX_CH2_DISK0_WRITE_RECOVERY;

   // field positions
   localparam int COUNT_LSB = 0;
   localparam int COUNT_MSB = 4;
   localparam int SECTOR_LOW_LSB = 2;
   localparam int BUF_GLOBAL_BIT = 0;
   localparam int BUF_CH2_DISK1_BIT = 3;

   // reset values
   localparam logic [7:0] TIMING_RESET = 8'h00;
   localparam logic [7:0] SECTOR_RESET = 8'h00;
   localparam logic [7:0] BUF_RESET = 8'h00;

   // count encoding: code 0 selects the longest time
   localparam logic [CLOCKS_W-1:0] MAX_CLOCKS = 6'h20;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [NUM_TIMING-1:0][CLOCKS_W-1:0] timing_clocks_t;

   typedef struct packed {
      logic [12:0] sector_bytes;
      logic ch2_disk1_buffer_use;
   } buffer_cfg_t;

endpackage

/* ide_timing_props.sv */
// assertions on the timing register bank ports
// bound to ide_pio_cycle_timing_regs from the bench top file
`timescale 1ns/10ps
`default_nettype none
module ide_timing_props
   import ide_timing_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   // outputs to the strobe sequencers
   input wire timing_clocks_t timing_clocks,
   input wire buffer_cfg_t buffer_cfg
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_ar_blocked: assert property (rvalid |-> !arready)
      else $error("read taken while one pending");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
      else $error("write answer late");
   a_ready_back: assert property (bvalid && bready |=> awready && wready)
      else $error("write channels not ready again");
   a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_sector_low: assert property (buffer_cfg.sector_bytes[1:0] == 2'h0)
      else $error("sector size not a multiple of four");
   a_code_range: assert property (timing_clocks[0] != 6'h00 && timing_clocks[0] <= MAX_CLOCKS)
      else $error("strobe time out of range");
   // counts may only move right after a store
   a_timing_quiet: assert property ($changed(timing_clocks) |-> $past(bvalid))
      else $error("timing changed without a write");
   c_write: cover property (awvalid && awready);
   c_read: cover property (arvalid && arready);
   c_error: cover property (bvalid && bresp == RESP_SLVERR);
endmodule
`default_nettype wire

/* ide_drive_model.sv */
// far-side drive view: the strobe time that applies to one access kind
// assumes sel names the count slot of the access under way
`timescale 1ns/10ps
`default_nettype none
module ide_drive_model
   import ide_timing_pkg::*;
(
   // counts from the bank
   input wire timing_clocks_t timing_clocks,
   input wire logic [3:0] sel,
   // strobe length in cpu clocks
   output logic [5:0] clocks
);
   // a drive only ever sees the slot of its own access
   assign clocks = timing_clocks[sel];
endmodule
`default_nettype wire

/* ide_pio_cycle_timing_regs_tb.sv */
// self-checking bench for the ide timing register bank
// assumes the package, checker and drive model are compiled first
`timescale 1ns/10ps
`default_nettype none
module ide_pio_cycle_timing_regs_tb;
   import ide_timing_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [31:0] rdata;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid;
   timing_clocks_t timing_clocks;
   buffer_cfg_t buffer_cfg;
   logic [3:0] sel = 4'h0;
   logic [5:0] seen_clocks;
   logic [4:0] code;
   logic [7:0] a;
   int n_mismatch = 0;
   int checked = 0;
   always #2 aclk = ~aclk;
   ide_pio_cycle_timing_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .timing_clocks(timing_clocks),
      .buffer_cfg(buffer_cfg));
   ide_drive_model drive (.timing_clocks(timing_clocks), .sel(sel), .clocks(seen_clocks));
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task final_report;
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ready is raised late so the held answer is exercised
   task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (n == 3) bready <= 1'b1;
         if (n > 40) begin
            n_mismatch++;
            final_report;
         end
      end while (!(bvalid && bready));
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
         if (n == 2) rready <= 1'b1;
         if (n > 40) begin
            n_mismatch++;
            final_report;
         end
      end while (!(rvalid && rready));
      rready <= 1'b0;
      chk("rdata", rdata, e);
      chk("rresp", 32'(rresp), 32'(er));
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int k = 0; k < NUM_TIMING; k++)
         chk("reset clocks", 32'(timing_clocks[k]), 32'h20);
      rd(8'h48, 32'h0, RESP_OKAY);
      for (int k = 0; k < NUM_TIMING; k++) begin
         sel <= 4'(k);
         code = (k == 12) ? 5'h1F : 5'(k);
         a = 8'((IDX_TIMING_FIRST + k) * 4);
         rd(a, 32'h0, RESP_OKAY);
         wr(a, {24'h0, 3'b111, code}, RESP_OKAY);
         rd(a, {27'h0, code}, RESP_OKAY);
         chk("strobe clocks", 32'(seen_clocks), (code == 0) ? 32'h20 : 32'(code));
      end
      wr(8'h44, 32'hFF, RESP_OKAY);
      rd(8'h44, 32'hFC, RESP_OKAY);
      wr(8'h48, 32'hE2, RESP_OKAY);
      rd(8'h48, 32'h02, RESP_OKAY);
      chk("sector bytes", 32'(buffer_cfg.sector_bytes), 32'h2FC);
      wr(8'h28, 32'h08, RESP_OKAY);
      rd(8'h28, 32'h08, RESP_OKAY);
      chk("buffer use", 32'(buffer_cfg.ch2_disk1_buffer_use), 32'h0);
      wr(8'h1C, 32'h01, RESP_OKAY);
      rd(8'h1C, 32'h01, RESP_OKAY);
      chk("buffer use", 32'(buffer_cfg.ch2_disk1_buffer_use), 32'h1);
      wr(8'h80, 32'h1F, RESP_SLVERR);
      rd(8'h80, 32'h0, RESP_SLVERR);
      final_report;
   end
endmodule
bind ide_pio_cycle_timing_regs ide_timing_props props (.*);
`default_nettype wire
